//--- rtl/ptpg_pkg.sv
// Constants and types for the pulse-train pattern generator
package ptpg_pkg;
  // Pattern shape limits
  localparam int MAX_PULSES = 10;
  localparam logic [3:0] CNT_MIN = 4'h1;
  localparam logic [3:0] CNT_MAX = 4'hA;
  localparam logic [3:0] CNT_RST = 4'h1;
  localparam logic [15:0] MAX_PTS = 16'hC350;
  localparam logic [15:0] PTS_RST = 16'h2710;
  // Period held in 10 ns units
  localparam int UNIT_NS = 10;
  localparam int CLK_PERIOD_NS = 100;
  localparam logic [39:0] CLK_UNITS = 40'(CLK_PERIOD_NS / UNIT_NS);
  localparam logic [39:0] PER_MIN = 40'h1;
  localparam logic [39:0] PER_MAX = 40'h2540BE400;
  localparam logic [39:0] PER_RST = 40'h2710;
  // Level, amplitude, width and delay codes
  localparam logic [15:0] BASE_RST = 16'h0000;
  localparam logic [15:0] LVL_RST = 16'h7FFF;
  localparam logic [15:0] AMP_RST = 16'h8000;
  localparam logic [15:0] WFR_RST = 16'h4000;
  localparam logic [16:0] DLY_RST = 17'h00000;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_COMMIT = 8'h04;
  localparam logic [7:0] OFF_PER_LO = 8'h08;
  localparam logic [7:0] OFF_PER_SETUP = 8'h0C;
  localparam logic [7:0] OFF_PER_RATE = 8'h10;
  localparam logic [7:0] OFF_BASE = 8'h14;
  localparam logic [7:0] OFF_AMP = 8'h18;
  localparam logic [7:0] OFF_SEL = 8'h1C;
  localparam logic [7:0] OFF_LVL = 8'h20;
  localparam logic [7:0] OFF_WIDTH = 8'h24;
  localparam logic [7:0] OFF_DELAY = 8'h28;
  localparam logic [7:0] OFF_ACT_W = 8'h2C;
  localparam logic [7:0] OFF_ACT_D = 8'h30;
  localparam logic [7:0] OFF_POINTS = 8'h34;
  localparam logic [7:0] OFF_STATUS = 8'h38;
  // Field positions
  localparam int CTRL_EXT_BIT = 4;
  localparam int CTRL_SRC_BIT = 5;
  localparam int CTRL_HOLD_BIT = 6;
  localparam int COMMIT_DONE_BIT = 0;
  localparam int COMMIT_NEXT_BIT = 1;
  // Pin positions in the synchroniser vector
  localparam int PIN_EXT = 0;
  localparam int PIN_SYS = 1;
  localparam int PIN_KEY = 2;
  localparam int PIN_HOLD = 3;
  localparam logic [3:0] PIN_IDLE = 4'h8;
  // Hold status codes
  typedef enum logic [1:0] {
    HOLD_NONE = 2'b00,
    HOLD_MAN = 2'b01,
    HOLD_EXT = 2'b10
  } ptpg_hold_t;
endpackage

//--- rtl/ptpg_top.sv
// Pulse-train pattern generator: registers, clocking, hold, playback
// Behaviour
// RULE1: Pattern holds one to ten pulses, each with level, width, delay.
// RULE2: Pattern is points at one point time; period is count times time.
// RULE3: Period accepted from 10 ns to 100 s, fine resolution.
// RULE4: Baseline level fills gaps and starts and ends every pulse.
// RULE5: Every pulse has its own signed level.
// RULE6: Amplitude scales baseline and all levels by one factor.
// RULE7: Width quantised to whole points; actual width read separately.
// RULE8: Point count never exceeds fifty thousand.
// RULE9: Signed delay within one period less a point, relative to sync.
// RULE10: Pattern rebuilt only on commit and only when changed.
// RULE11: Controller keeps pulses from overlapping or passing the period.
// RULE12: Period change rescales widths and delays proportionally.
// RULE13: Rate-only period change keeps the point count fixed.
// RULE14: Set-up period change reduces point count for short periods.
// RULE15: External clock takes over only at its first rising edge.
// RULE16: External mode: one point per external clock, count unchanged.
// RULE17: External source selectable: clock port or system clock.
// RULE18: Hold-enable setting gates both pause sources.
// RULE19: Each pause key press toggles pause; resume from same point.
// RULE20: Low hold input freezes output; high resumes from there.
// RULE21: Hold status shows none, manual or external hold.
// RULE22: Pause and clock pins pass a multi-stage synchroniser.
//
// The register addresses and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module ptpg_top (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic ext_clk_in,
  input wire logic sys_clk_in,
  input wire logic manual_pause_key,
  input wire logic hold_in,
  output logic [15:0] sample_out,
  output logic sync_out,
  output ptpg_pkg::ptpg_hold_t hold_status
);
  import ptpg_pkg::*;

  logic [3:0] cnt_reg;
  logic ext_req_reg;
  logic src_sys_reg;
  logic hold_en_reg;
  logic [31:0] per_lo_reg;
  logic [39:0] period_reg;
  logic [15:0] pts_reg;
  logic [15:0] base_reg;
  logic [15:0] amp_reg;
  logic [3:0] sel_reg;
  logic [15:0] lvl_mem [MAX_PULSES];
  logic [15:0] wfr_mem [MAX_PULSES];
  logic [16:0] dly_mem [MAX_PULSES];
  logic [3:0] a_cnt_reg;
  logic [15:0] a_base_reg;
  logic [15:0] a_lvl_reg [MAX_PULSES];
  logic [15:0] a_wfr_reg [MAX_PULSES];
  logic [16:0] a_dly_reg [MAX_PULSES];
  logic dirty_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rd_next;

  //////////////////////////////////////////////////////////////////////
  // Register decode
  logic wr_ctrl, wr_commit, wr_lo, wr_setup, wr_rate;
  logic wr_base, wr_lvl, wr_width, wr_delay, set_w;
  assign wr_ctrl = reg_wr && (reg_addr == OFF_CTRL);
  assign wr_commit = reg_wr && (reg_addr == OFF_COMMIT);
  assign wr_lo = reg_wr && (reg_addr == OFF_PER_LO);
  assign wr_setup = reg_wr && (reg_addr == OFF_PER_SETUP);
  assign wr_rate = reg_wr && (reg_addr == OFF_PER_RATE);
  assign wr_base = reg_wr && (reg_addr == OFF_BASE);
  assign wr_lvl = reg_wr && (reg_addr == OFF_LVL);
  assign wr_width = reg_wr && (reg_addr == OFF_WIDTH);
  assign wr_delay = reg_wr && (reg_addr == OFF_DELAY);
  // Any pattern edit makes the built pattern stale
  assign set_w = wr_ctrl || wr_base || wr_lvl || wr_width || wr_delay;

  // Count clamped into range on write
  logic [3:0] cnt_next;
  // RULE1: pulse count range
  always_comb
  begin
    cnt_next = reg_wdata[3:0];
    if (cnt_next < CNT_MIN)
      cnt_next = CNT_MIN;
    else if (cnt_next > CNT_MAX)
      cnt_next = CNT_MAX;
  end

  // Control bits
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt_reg <= CNT_RST;
      ext_req_reg <= 1'b0;
      src_sys_reg <= 1'b0;
      hold_en_reg <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      cnt_reg <= cnt_next;
      ext_req_reg <= reg_wdata[CTRL_EXT_BIT];
      // RULE17: external source choice
      src_sys_reg <= reg_wdata[CTRL_SRC_BIT];
      // RULE18: channel hold enable
      hold_en_reg <= reg_wdata[CTRL_HOLD_BIT];
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Period and point count
  logic [39:0] per_new, per_cl;
  assign per_new = {reg_wdata[7:0], per_lo_reg};
  // RULE3: period range clamp
  assign per_cl = (per_new < PER_MIN) ? PER_MIN :
                  (per_new > PER_MAX) ? PER_MAX : per_new;

  // High word applies the staged low word in one step
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      per_lo_reg <= 32'h0000_0000;
      period_reg <= PER_RST;
      pts_reg <= PTS_RST;
    end
    else if (wr_lo)
      per_lo_reg <= reg_wdata;
    else if (wr_setup)
    begin
      period_reg <= per_cl;
      // RULE14: short periods shed points
      // RULE8: point count ceiling
      if (per_cl > {24'h0, MAX_PTS})
        pts_reg <= MAX_PTS;
      else
        pts_reg <= per_cl[15:0];
    end
    else if (wr_rate)
    begin
      // RULE13: count fixed, period floored
      if (per_cl < {24'h0, pts_reg})
        period_reg <= {24'h0, pts_reg};
      else
        period_reg <= per_cl;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Pattern settings; baseline staged until commit, amplitude and select take effect at once
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      base_reg <= BASE_RST;
      amp_reg <= AMP_RST;
      sel_reg <= 4'h0;
    end
    else
    begin
      if (wr_base)
        base_reg <= reg_wdata[15:0];
      if (reg_wr && (reg_addr == OFF_AMP))
        amp_reg <= reg_wdata[15:0];
      // Clamped so the entry index stays inside the table
      if (reg_wr && (reg_addr == OFF_SEL))
        sel_reg <= (reg_wdata[3:0] > 4'h9) ? 4'h9 : reg_wdata[3:0];
    end
  end

  // Per-pulse tables: edit copy and playing copy
  logic commit_go, build_go;
  genvar g;
  generate
    for (g = 0; g < MAX_PULSES; g++)
    begin : g_mem
      always_ff @(posedge clock or negedge nrst)
      begin
        if (!nrst)
        begin
          lvl_mem[g] <= LVL_RST;
          wfr_mem[g] <= WFR_RST;
          dly_mem[g] <= DLY_RST;
          a_lvl_reg[g] <= LVL_RST;
          a_wfr_reg[g] <= WFR_RST;
          a_dly_reg[g] <= DLY_RST;
        end
        else
        begin
          // RULE5: own level per pulse
          if (wr_lvl && (sel_reg == 4'(g)))
            lvl_mem[g] <= reg_wdata[15:0];
          if (wr_width && (sel_reg == 4'(g)))
            wfr_mem[g] <= reg_wdata[15:0];
          if (wr_delay && (sel_reg == 4'(g)))
            dly_mem[g] <= reg_wdata[16:0];
          // RULE10: playing copy loads on commit
          if (build_go)
          begin
            a_lvl_reg[g] <= lvl_mem[g];
            a_wfr_reg[g] <= wfr_mem[g];
            a_dly_reg[g] <= dly_mem[g];
          end
        end
      end
    end
  endgenerate

  // RULE10: commit on finish or next on last pulse
  assign commit_go = wr_commit && (reg_wdata[COMMIT_DONE_BIT] ||
    (reg_wdata[COMMIT_NEXT_BIT] && (sel_reg == cnt_reg - 4'h1)));
  assign build_go = commit_go && dirty_reg;

  // Edit flag; an edit beats a clear in the same cycle
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      dirty_reg <= 1'b0;
      a_cnt_reg <= CNT_RST;
      a_base_reg <= BASE_RST;
    end
    else
    begin
      if (set_w)
        dirty_reg <= 1'b1;
      else if (build_go)
        dirty_reg <= 1'b0;
      if (build_go)
      begin
        a_cnt_reg <= cnt_reg;
        a_base_reg <= base_reg;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Pin synchroniser: three stages, change taken when two agree
  logic [3:0] pins, s1_reg, s2_reg, s3_reg, filt_reg, rise;
  assign pins = {hold_in, manual_pause_key, sys_clk_in, ext_clk_in};
  // RULE22: pins synchronised before use
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      s1_reg <= PIN_IDLE;
      s2_reg <= PIN_IDLE;
      s3_reg <= PIN_IDLE;
      filt_reg <= PIN_IDLE;
    end
    else
    begin
      s1_reg <= pins;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      filt_reg <= (s2_reg & s3_reg) | (filt_reg & (s2_reg | s3_reg));
    end
  end
  assign rise = s2_reg & s3_reg & ~filt_reg;

  //////////////////////////////////////////////////////////////////////
  // Point clock: rate accumulator stands in for a division
  logic [39:0] acc_reg, acc_sum, acc_left;
  logic dds_tick;
  // RULE2: pts points per period
  assign acc_sum = acc_reg + 40'(pts_reg) * CLK_UNITS;
  assign acc_left = acc_sum - period_reg;
  assign dds_tick = (acc_sum >= period_reg);
  // Saturates at one point per cycle for very short periods
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      acc_reg <= 40'h0;
    else if (!dds_tick)
      acc_reg <= acc_sum;
    else if (acc_left >= period_reg)
      acc_reg <= 40'h0;
    else
      acc_reg <= acc_left;
  end

  // External clock takeover
  logic src_rise, ext_active_reg, tick;
  // RULE17: source mux
  assign src_rise = src_sys_reg ? rise[PIN_SYS] : rise[PIN_EXT];
  // RULE15: switch at first rising edge
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      ext_active_reg <= 1'b0;
    else if (!ext_req_reg)
      ext_active_reg <= 1'b0;
    else if (src_rise)
      ext_active_reg <= 1'b1;
  end
  // RULE16: one point per external edge
  assign tick = ext_active_reg ? src_rise : dds_tick;

  //////////////////////////////////////////////////////////////////////
  // Hold control
  logic manual_pause_key_reg, ext_low, paused;
  ptpg_hold_t hold_reg;
  assign ext_low = ~filt_reg[PIN_HOLD];
  // RULE18: only enabled channel pauses
  assign paused = hold_en_reg && (manual_pause_key_reg || ext_low);
  // RULE19: key press toggles pause
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      manual_pause_key_reg <= 1'b0;
    else if (!hold_en_reg)
      manual_pause_key_reg <= 1'b0;
    else if (rise[PIN_KEY])
      manual_pause_key_reg <= ~manual_pause_key_reg;
  end
  // RULE21: hold status, external reported first
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      hold_reg <= HOLD_NONE;
    else if (hold_en_reg && ext_low)
      hold_reg <= HOLD_EXT;
    else if (hold_en_reg && manual_pause_key_reg)
      hold_reg <= HOLD_MAN;
    else
      hold_reg <= HOLD_NONE;
  end

  //////////////////////////////////////////////////////////////////////
  // Playback index and sync
  logic [15:0] idx_reg;
  logic adv, sync_reg;
  // RULE20: paused index stands still
  assign adv = tick && !paused && (idx_reg < pts_reg);
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      idx_reg <= 16'h0;
    else if (idx_reg >= pts_reg)
      idx_reg <= 16'h0;
    else if (adv)
      idx_reg <= (idx_reg == pts_reg - 16'h1) ? 16'h0 : idx_reg + 16'h1;
  end
  // Sync marks the start of point zero
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      sync_reg <= 1'b0;
    else
      sync_reg <= adv && (idx_reg == pts_reg - 16'h1);
  end

  //////////////////////////////////////////////////////////////////////
  // Per-pulse placement from period fractions
  logic [9:0] act;
  logic [15:0] w_pts [MAX_PULSES];
  logic [15:0] st_pts [MAX_PULSES];
  generate
    for (g = 0; g < MAX_PULSES; g++)
    begin : g_pulse
      logic [31:0] wprod;
      logic [16:0] dmag;
      logic [32:0] dprod;
      logic [15:0] wq, dq, st;
      logic [16:0] off;
      // RULE12: fractions follow any period change
      // RULE7: width in whole points, one at least
      assign wprod = a_wfr_reg[g] * pts_reg;
      assign wq = (wprod[31:16] == 16'h0) ? 16'h1 : wprod[31:16];
      // RULE9: signed delay kept below one period
      assign dmag = a_dly_reg[g][16] ? 17'(-a_dly_reg[g]) : a_dly_reg[g];
      assign dprod = dmag * pts_reg;
      assign dq = (dprod[32:16] >= {1'b0, pts_reg}) ?
                  pts_reg - 16'h1 : dprod[31:16];
      assign st = !a_dly_reg[g][16] ? dq :
                  ((dq == 16'h0) ? 16'h0 : pts_reg - dq);
      // Wrapped distance so a negative delay may cross sync
      assign off = (idx_reg >= st) ? {1'b0, idx_reg} - {1'b0, st} :
                   {1'b0, idx_reg} + {1'b0, pts_reg} - {1'b0, st};
      // RULE1: pulses beyond count stay silent
      assign act[g] = (4'(g) < a_cnt_reg) && (off < {1'b0, wq});
      assign w_pts[g] = wq;
      assign st_pts[g] = st;
    end
  endgenerate

  // Overlaps are the controller's fault; lowest pulse wins
  logic [15:0] lvl_sel;
  // RULE4: baseline between pulses
  always_comb
  begin
    lvl_sel = a_base_reg;
    for (int i = MAX_PULSES - 1; i >= 0; i--)
      if (act[i])
        lvl_sel = a_lvl_reg[i];
  end

  // RULE6: one factor for every level
  logic signed [32:0] prod;
  assign prod = $signed(lvl_sel) * $signed({1'b0, amp_reg});
  // Output frozen while paused
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      sample_out <= BASE_RST;
    else if (!paused)
      sample_out <= prod[30:15];
  end

  //////////////////////////////////////////////////////////////////////
  // Read port: data only in the cycle after the strobe
  always_comb
  begin
    rd_next = 32'h0;
    case (reg_addr)
      OFF_CTRL: rd_next = {25'h0, hold_en_reg, src_sys_reg,
                           ext_req_reg, cnt_reg};
      OFF_PER_LO: rd_next = period_reg[31:0];
      OFF_PER_SETUP: rd_next = {24'h0, period_reg[39:32]};
      OFF_PER_RATE: rd_next = {24'h0, period_reg[39:32]};
      OFF_BASE: rd_next = {16'h0, base_reg};
      OFF_AMP: rd_next = {16'h0, amp_reg};
      OFF_SEL: rd_next = {28'h0, sel_reg};
      OFF_LVL: rd_next = {16'h0, lvl_mem[sel_reg]};
      OFF_WIDTH: rd_next = {16'h0, wfr_mem[sel_reg]};
      OFF_DELAY: rd_next = {{15{dly_mem[sel_reg][16]}}, dly_mem[sel_reg]};
      // RULE7: actual width reported apart
      OFF_ACT_W: rd_next = {16'h0, w_pts[sel_reg]};
      OFF_ACT_D: rd_next = {16'h0, st_pts[sel_reg]};
      OFF_POINTS: rd_next = {16'h0, pts_reg};
      OFF_STATUS: rd_next = {28'h0, dirty_reg, ext_active_reg, hold_reg};
      default: rd_next = 32'h0;
    endcase
  end
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      rdata_reg <= 32'h0;
    else
      rdata_reg <= reg_rd ? rd_next : 32'h0;
  end

  assign reg_rdata = rdata_reg;
  assign sync_out = sync_reg;
  assign hold_status = hold_reg;

  //////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);

  sequence key_seq;
    hold_en_reg && rise[PIN_KEY] && !wr_ctrl;
  endsequence
  sequence ext_edge_seq;
    ext_req_reg && src_rise && !wr_ctrl;
  endsequence

  commit_load_a: // RULE10
    assert property (build_go |=> a_cnt_reg == $past(cnt_reg) && !dirty_reg)
    else $error("commit did not load pattern");
  commit_keep_a: // RULE10
    assert property (!build_go |=> $stable(a_cnt_reg) && $stable(a_base_reg))
    else $error("pattern changed without commit");
  rate_keep_a: // RULE13
    assert property (wr_rate |=> $stable(pts_reg))
    else $error("rate path changed point count");
  setup_pts_a: // RULE14
    assert property (wr_setup && per_cl <= {24'h0, MAX_PTS}
                     |=> pts_reg == $past(per_cl[15:0]))
    else $error("setup path point count wrong");
  pts_limit_a: // RULE8
    assert property (pts_reg <= MAX_PTS && pts_reg != 16'h0)
    else $error("point count out of range");
  cnt_range_a: // RULE1
    assert property (a_cnt_reg >= CNT_MIN && a_cnt_reg <= CNT_MAX)
    else $error("pulse count out of range");
  per_range_a: // RULE3
    assert property (period_reg >= PER_MIN && period_reg <= PER_MAX)
    else $error("period out of range");
  ext_wait_a: // RULE15
    assert property (ext_req_reg && !ext_active_reg && !src_rise
                     |=> !ext_active_reg)
    else $error("switched before external edge");
  ext_take_a: // RULE15
    assert property (ext_edge_seq |=> ext_active_reg [*2] or
                     (ext_active_reg ##1 !ext_req_reg))
    else $error("external edge not taken");
  ext_tick_a: // RULE16
    assert property (ext_active_reg |-> tick == src_rise)
    else $error("point step not on external edge");
  key_toggle_a: // RULE19
    assert property (key_seq |=> manual_pause_key_reg != $past(manual_pause_key_reg))
    else $error("pause key did not toggle");
  hold_freeze_a: // RULE20
    assert property (paused && !wr_setup && idx_reg < pts_reg
                     |=> $stable(idx_reg) && $stable(sample_out))
    else $error("playback moved while paused");
  hold_stat_a: // RULE21
    assert property (hold_reg == HOLD_EXT |-> $past(hold_en_reg && ext_low))
    else $error("external hold status wrong");
  sync_zero_a: // RULE9
    assert property (sync_reg && !$past(wr_setup) |-> idx_reg == 16'h0)
    else $error("sync not at point zero");
endmodule // ptpg_top
`default_nettype wire

//--- tb/ptpg_out_model.sv
// Output converter model: level extremes and sync spacing
`timescale 1ns/1ps
`default_nettype none
module ptpg_out_model (
  input wire logic clock,
  input wire logic nrst,
  input wire logic clear,
  input wire logic [15:0] sample_out,
  input wire logic sync_out,
  output logic signed [15:0] peak,
  output logic signed [15:0] low,
  output logic [15:0] gap,
  output logic [7:0] n_sync
);
  logic [15:0] cnt;
  // Converter takes a sample every cycle; a clear restarts the extremes and the sync count, not the gap
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst || clear)
    begin
      peak <= 16'sh8000;
      low <= 16'sh7FFF;
      n_sync <= 8'h00;
    end
    else
    begin
      if ($signed(sample_out) > peak) peak <= $signed(sample_out);
      if ($signed(sample_out) < low) low <= $signed(sample_out);
      if (sync_out) n_sync <= n_sync + 8'h01;
    end
  end
  // Cycles between two sync pulses, i.e. one pattern period
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt <= 16'h0001;
      gap <= 16'h0000;
    end
    else if (sync_out)
    begin
      gap <= cnt;
      cnt <= 16'h0001;
    end
    else
      cnt <= cnt + 16'h0001;
  end
endmodule // ptpg_out_model
`default_nettype wire

//--- tb/ptpg_top_tb.sv
// Self-checking bench for the pulse-train pattern generator
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fails++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module ptpg_top_tb;
  import ptpg_pkg::*;
  logic clock = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
  logic ext_clk_in = 1'b0, sys_clk_in = 1'b0, manual_pause_key = 1'b0;
  logic hold_in = 1'b1, clear = 1'b0, ext_run = 1'b0, sync_out;
  logic [15:0] sample_out, gap, s;
  logic signed [15:0] peak, low;
  logic [7:0] n_sync;
  ptpg_hold_t hold_status;
  int fails = 0, checked = 0;
  ptpg_top i_ptpg_top (.clock(clock), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .ext_clk_in(ext_clk_in), .sys_clk_in(sys_clk_in),
    .manual_pause_key(manual_pause_key), .hold_in(hold_in),
    .sample_out(sample_out), .sync_out(sync_out), .hold_status(hold_status));
  ptpg_out_model i_ptpg_out_model (.clock(clock), .nrst(nrst), .clear(clear),
    .sample_out(sample_out), .sync_out(sync_out), .peak(peak), .low(low),
    .gap(gap), .n_sync(n_sync));
  // 10 MHz clock
  always #50 clock = ~clock;
  // Pin clocks from a cycle count: 10 and 20 clocks per period
  int pc = 0;
  always @(posedge clock)
  begin
    pc <= pc + 1;
    if (ext_run && pc % 5 == 4)
      ext_clk_in <= ~ext_clk_in;
    if (pc % 10 == 9)
      sys_clk_in <= ~sys_clk_in;
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    reg_addr <= a; reg_wdata <= v; reg_wr <= 1'b1;
    @(posedge clock); reg_wr <= 1'b0;
    @(posedge clock);
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    reg_addr <= a; reg_rd <= 1'b1;
    @(posedge clock); reg_rd <= 1'b0;
    @(negedge clock); v = reg_rdata;
    @(posedge clock);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    rd(a, d);
    `CHK(d, e)
  endtask
  task automatic run(input int n);
    clear <= 1'b1; @(posedge clock); clear <= 1'b0;
    repeat (n) @(posedge clock);
    // Step past the edge so outputs are looked at once settled
    #1;
  endtask
  // Pins are held long enough to pass the input synchroniser
  task automatic press;
    manual_pause_key <= 1'b1; repeat (5) @(posedge clock);
    manual_pause_key <= 1'b0; repeat (6) @(posedge clock);
    #1;
  endtask
  //////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rchk(OFF_POINTS, 32'h2710);
    rchk(OFF_CTRL, 32'h1);
    rchk(OFF_STATUS, 32'h0);
    `CHK(hold_status, HOLD_NONE)
  endtask
  task automatic t_count;
    wr(OFF_CTRL, 32'hF);
    rchk(OFF_CTRL, 32'hA);
    wr(OFF_CTRL, 32'h0);
    rchk(OFF_CTRL, 32'h1);
  endtask
  task automatic t_period;
    wr(OFF_PER_LO, 32'd20); wr(OFF_PER_SETUP, 32'h0);
    rchk(OFF_POINTS, 32'd20);
    rchk(OFF_ACT_W, 32'd5);
    run(60);
    `CHK(gap, 16'd20)
    wr(OFF_PER_LO, 32'd5); wr(OFF_PER_RATE, 32'h0);
    rchk(OFF_POINTS, 32'd20);
    rchk(OFF_PER_LO, 32'd20);
    wr(OFF_PER_LO, 32'd40); wr(OFF_PER_RATE, 32'h0);
    rchk(OFF_ACT_W, 32'd5);
    wr(OFF_PER_LO, 32'hEA60); wr(OFF_PER_SETUP, 32'h0);
    rchk(OFF_POINTS, 32'hC350);
    wr(OFF_PER_LO, 32'd20); wr(OFF_PER_SETUP, 32'h0);
  endtask
  // pulses kept apart
  // One quarter-width pulse at delay 0 keeps clear of the period end
  task automatic t_level;
    wr(OFF_COMMIT, 32'h1); run(50);
    `CHK(peak, 16'sh7FFF)
    `CHK(low, 16'sh0000)
    wr(OFF_LVL, 32'h2000); wr(OFF_BASE, 32'hF000); run(50);
    `CHK(peak, 16'sh7FFF)
    wr(OFF_COMMIT, 32'h1); run(50);
    `CHK(peak, 16'sh2000)
    `CHK(low, 16'shF000)
    wr(OFF_AMP, 32'h4000); run(50);
    `CHK(peak, 16'sh1000)
    `CHK(low, 16'shF800)
  endtask
  task automatic t_hold;
    wr(OFF_CTRL, 32'h41); wr(OFF_COMMIT, 32'h1); press;
    `CHK(hold_status, HOLD_MAN)
    s = sample_out; run(40);
    `CHK(n_sync, 8'h00)
    `CHK(sample_out, s)
    press; run(40);
    `CHK(hold_status, HOLD_NONE)
    `CHK(n_sync > 8'h0, 1'b1)
    hold_in <= 1'b0; run(8);
    `CHK(hold_status, HOLD_EXT)
    s = sample_out;
    run(40);
    `CHK(n_sync, 8'h00)
    `CHK(sample_out, s)
    hold_in <= 1'b1; run(40);
    `CHK(n_sync > 8'h0, 1'b1)
    wr(OFF_CTRL, 32'h01); hold_in <= 1'b0; press;
    `CHK(hold_status, HOLD_NONE)
    hold_in <= 1'b1; run(6);
  endtask
  task automatic t_ext;
    wr(OFF_CTRL, 32'h11); run(20);
    rd(OFF_STATUS, d);
    `CHK(d[2], 1'b0)
    ext_run <= 1'b1; run(30);
    rd(OFF_STATUS, d);
    `CHK(d[2], 1'b1)
    run(600);
    `CHK(gap, 16'd200)
    rchk(OFF_POINTS, 32'd20);
    wr(OFF_CTRL, 32'h31); run(1200);
    `CHK(gap, 16'd400)
    ext_run <= 1'b0; wr(OFF_CTRL, 32'h01);
  endtask
  // single pulse, no overlap
  // Half-width pulse five points before sync; next-confirm commits
  task automatic t_place;
    wr(OFF_WIDTH, 32'h8000);
    wr(OFF_DELAY, 32'h1C000);
    wr(OFF_SEL, 32'h1);
    wr(OFF_COMMIT, 32'h2);
    rd(OFF_STATUS, d);
    `CHK(d[3], 1'b1)
    wr(OFF_SEL, 32'h0);
    wr(OFF_COMMIT, 32'h2);
    rd(OFF_STATUS, d);
    `CHK(d[3], 1'b0)
    rchk(OFF_WIDTH, 32'h8000);
    rchk(OFF_ACT_W, 32'hA);
    rchk(OFF_ACT_D, 32'hF);
    rchk(OFF_DELAY, 32'hFFFFC000);
  endtask
  //////////////////////////////////////////////////////////////////////////
  task automatic conclude;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Watchdog well beyond the planned run length
  initial
  begin
    #(100 * 20000);
    fails++;
    conclude();
  end
  initial
  begin
    repeat (12) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    t_reset();
    t_count();
    t_period();
    t_level();
    t_hold();
    t_ext();
    t_place();
    conclude();
  end
endmodule // ptpg_top_tb
`default_nettype wire
